//--- common/line_port_defines.svh
// offsets, field positions, reset values and timing counts of the line port
// assumes a 250 MHz system clock and word-aligned register byte addresses
`ifndef LINE_PORT_DEFINES_SVH
`define LINE_PORT_DEFINES_SVH

// line map: one index covers all groups
`define DLP_NLINES        20
`define DLP_GRP_A_LSB     0
`define DLP_GRP_B_LSB     8
`define DLP_DEDIC_LSB     16
`define DLP_ABSENT_MASK   20'h0_000F

// register byte addresses
`define DLP_OFF_DIR       8'h00
`define DLP_OFF_LEVEL     8'h04
`define DLP_OFF_PINS      8'h08
`define DLP_OFF_PU_DIR    8'h0C
`define DLP_OFF_PU_LEVEL  8'h10
`define DLP_OFF_XCHG      8'h14
`define DLP_OFF_STATUS    8'h18

// status fields
`define DLP_ST_RUN        0
`define DLP_ST_HV         1

// reset values: factory default is every line an input
`define DLP_RST_DIR       20'h0_0000
`define DLP_RST_LEVEL     20'h0_0000

// power-up hold window
`define DLP_CLK_NS        4
`define DLP_STARTUP_MS    5
`define DLP_STARTUP_CYCLES \
    (((`DLP_STARTUP_MS * 1000000) + `DLP_CLK_NS - 1) / `DLP_CLK_NS)

`endif

//--- common/line_port_pkg.sv
// types shared by the line port and its bench
// assumes the constants of line_port_defines.svh
package line_port_pkg;

    // pad controls of all twenty lines
    typedef struct packed {
        logic [19:0] drive;
        logic [19:0] oe;
        logic [19:0] pull_en;
    } pad_ctrl_t;

    // power-up phases
    typedef enum logic [1:0] {
        PH_HOLD,
        PH_LOAD,
        PH_RUN
    } phase_t;

endpackage : line_port_pkg

//--- rtl/line_cell.sv
// one digital line: pin synchroniser and registered pad controls
// assumes pin_in is asynchronous and the pad resolves drive, oe, pull_en
`timescale 1ns/1ps

module line_cell #(
    parameter bit ALWAYS_PRESENT = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic present,
    input  wire logic hold,
    input  wire logic dir,
    input  wire logic level,
    input  wire logic pin_in,
    output logic      pin_sync,
    output logic      drive,
    output logic      oe,
    output logic      pull_en
);

    logic sync1_q;
    logic sync2_q;
    logic avail;
    logic out_en;

    // absent lines never drive and never pull
    assign avail    = ALWAYS_PRESENT | present;
    assign out_en   = avail & ~hold & dir;
    assign pin_sync = avail & sync2_q;

    ////////////////////////////////////////////////////////////////////
    // two-flop synchroniser, then registered pad controls
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            oe      <= 1'b0;
            drive   <= 1'b0;
            pull_en <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            oe      <= out_en;
            drive   <= out_en & level;
            pull_en <= avail & ~out_en;
        end
    end

endmodule : line_cell

//--- rtl/digital_line_port.sv
// digital line port: twenty three-state lines behind a register port
// assumes one 250 MHz clock, asynchronous pins, external pad resolution
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "line_port_defines.svh"

module digital_line_port
    import line_port_pkg::*;
#(
    parameter bit          HV_VARIANT     = 1'b0,
    parameter int unsigned STARTUP_CYCLES = `DLP_STARTUP_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [19:0] pin_in,
    output pad_ctrl_t        pads,
    output logic             startup_done
);

    ////////////////////////////////////////////////////////////////////
    // declarations
    logic [19:0] present;
    logic        hold;
    phase_t      phase_q;
    phase_t      phase_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        cnt_last;
    logic [19:0] dir_q;
    logic [19:0] dir_d;
    logic [19:0] level_q;
    logic [19:0] level_d;
    logic [19:0] pu_dir_q;
    logic [19:0] pu_dir_d;
    logic [19:0] pu_level_q;
    logic [19:0] pu_level_d;
    logic [19:0] snap_q;
    logic [19:0] snap_d;
    logic [19:0] pin_sync;
    logic [19:0] wdata20;
    logic        wr_dir;
    logic        wr_level;
    logic        wr_pu_dir;
    logic        wr_pu_level;
    logic        wr_xchg;
    logic [31:0] status_word;
    logic [31:0] rd_mux;
    logic        ph_load;

    ////////////////////////////////////////////////////////////////////
    // line availability: the variant drops the low four lines
    assign present = HV_VARIANT ? ~`DLP_ABSENT_MASK
                                : 20'hF_FFFF;

    // one cell per line index, bit n is line n
    genvar gi;
    generate
        for (gi = 0; gi < `DLP_NLINES; gi++) begin : g_line
            line_cell #(
                .ALWAYS_PRESENT (1'b0)
            ) u_cell (
                .clk_sys  (clk_sys),
                .rst_n    (rst_n),
                .present  (present[gi]),
                .hold     (hold),
                .dir      (dir_q[gi]),
                .level    (level_q[gi]),
                .pin_in   (pin_in[gi]),
                .pin_sync (pin_sync[gi]),
                .drive    (pads.drive[gi]),
                .oe       (pads.oe[gi]),
                .pull_en  (pads.pull_en[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // power-up sequencer: hold all inputs, then load stored state
    assign cnt_last = (cnt_q == STARTUP_CYCLES - 1);
    assign hold     = (phase_q != PH_RUN);
    assign ph_load  = (phase_q == PH_LOAD);

    always_comb begin
        phase_d = phase_q;
        cnt_d   = cnt_q;
        case (phase_q)
            PH_HOLD: begin
                cnt_d = cnt_q + 32'h0000_0001;
                if (cnt_last) begin
                    phase_d = PH_LOAD;
                end
            end
            PH_LOAD: begin
                phase_d = PH_RUN;
            end
            PH_RUN: begin
                phase_d = PH_RUN;
            end
            default: begin
                phase_d = PH_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_q      <= PH_HOLD;
            cnt_q        <= 32'h0000_0000;
            startup_done <= 1'b0;
        end else begin
            phase_q      <= phase_d;
            cnt_q        <= cnt_d;
            startup_done <= (phase_d == PH_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write decode
    assign wdata20     = reg_wdata[19:0] & present;
    assign wr_dir      = reg_wr & (reg_addr == `DLP_OFF_DIR);
    assign wr_level    = reg_wr & (reg_addr == `DLP_OFF_LEVEL);
    assign wr_pu_dir   = reg_wr & (reg_addr == `DLP_OFF_PU_DIR);
    assign wr_pu_level = reg_wr & (reg_addr == `DLP_OFF_PU_LEVEL);
    assign wr_xchg     = reg_wr & (reg_addr == `DLP_OFF_XCHG);

    // the load of stored state wins over a write in the same cycle,
    // so software sees the power-up state take effect exactly once
    assign dir_d   = ph_load ? (pu_dir_q & present)
                   : wr_dir  ? wdata20
                   : dir_q;
    assign level_d = ph_load ? (pu_level_q & present)
                   : (wr_level | wr_xchg) ? wdata20
                   : level_q;
    // the first group's byte sits in bits 7:0 of the power-up word
    assign pu_dir_d   = wr_pu_dir   ? wdata20 : pu_dir_q;
    assign pu_level_d = wr_pu_level ? wdata20 : pu_level_q;
    // exchange captures the lines as they were before the new levels
    assign snap_d     = wr_xchg ? pin_sync : snap_q;

    // live and stored state; stored state survives soft restarts only
    // because nothing but rst_n clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_q      <= `DLP_RST_DIR;
            level_q    <= `DLP_RST_LEVEL;
            pu_dir_q   <= `DLP_RST_DIR;
            pu_level_q <= `DLP_RST_LEVEL;
            snap_q     <= 20'h0_0000;
        end else begin
            dir_q      <= dir_d;
            level_q    <= level_d;
            pu_dir_q   <= pu_dir_d;
            pu_level_q <= pu_level_d;
            snap_q     <= snap_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses read as zero
    assign status_word = {30'h0000_0000, HV_VARIANT, (phase_q == PH_RUN)};
    assign rd_mux =
        (reg_addr == `DLP_OFF_DIR)      ? {12'h000, dir_q}      :
        (reg_addr == `DLP_OFF_LEVEL)    ? {12'h000, level_q}    :
        (reg_addr == `DLP_OFF_PINS)     ? {12'h000, pin_sync}   :
        (reg_addr == `DLP_OFF_PU_DIR)   ? {12'h000, pu_dir_q}   :
        (reg_addr == `DLP_OFF_PU_LEVEL) ? {12'h000, pu_level_q} :
        (reg_addr == `DLP_OFF_XCHG)     ? {12'h000, snap_q}     :
        (reg_addr == `DLP_OFF_STATUS)   ? status_word           :
        32'h0000_0000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    // no line drives while the power-up window is open
    chk_hold_no_drive: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (phase_q != PH_RUN) |=> (pads.oe == 20'h0_0000))
        else $error("line driven during power-up hold");

    // the window lasts the full count, then load, then run
    chk_startup_len: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (phase_q == PH_HOLD) && cnt_last
        |=> (phase_q == PH_LOAD) ##1 (phase_q == PH_RUN) && startup_done)
        else $error("power-up window sequence wrong");

    chk_hold_stays: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (phase_q == PH_HOLD) && !cnt_last |=> (phase_q == PH_HOLD))
        else $error("power-up window ended early");

    // stored state is applied at the end of the window
    chk_load_stored: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ph_load |=> (dir_q == ($past(pu_dir_q) & present))
                 && (level_q == ($past(pu_level_q) & present)))
        else $error("stored power-up state not applied");

    // absent lines neither drive nor pull
    chk_absent_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ((pads.oe | pads.pull_en | pads.drive) & ~present) == 20'h0_0000)
        else $error("absent line active");

    // every present line is either pulled-up input or driven
    chk_pull_or_drive: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $past(rst_n) |->
        ((pads.oe & pads.pull_en) == 20'h0_0000)
        && ((pads.oe | pads.pull_en) == present))
        else $error("line neither pulled up nor driven");

    // driven value follows direction and level one cycle later
    chk_drive_level: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (phase_q == PH_RUN) |=>
        (pads.oe == $past(dir_q)) && (pads.drive == $past(dir_q & level_q)))
        else $error("pad controls do not follow direction and level");

    // exchange writes all levels and captures all lines at once
    chk_xchg_both: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_xchg && !ph_load |=>
        (level_q == $past(wdata20)) && (snap_q == $past(pin_sync)))
        else $error("exchange did not write and capture");

    // power-up direction byte: bit n is line n of the first group
    chk_pu_dir_byte: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_pu_dir |=> pu_dir_q[7:0] == ($past(reg_wdata[7:0]) & present[7:0]))
        else $error("power-up direction byte not stored");

    // line read puts line n on bit n the cycle after the strobe
    chk_pin_read: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        reg_rd && (reg_addr == `DLP_OFF_PINS)
        |=> (reg_rdata == {12'h000, $past(pin_sync)}) ##1 !$past(reg_rd)
            [*1] |-> (reg_rdata == 32'h0000_0000))
        else $error("line read wrong");

endmodule : digital_line_port

//--- test/line_pad_model.sv
// far-side model of the twenty lines: resolves each wire level
// assumes pads come from digital_line_port and the bench drives ext_*
`timescale 1ns/1ps

module line_pad_model
    import line_port_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire pad_ctrl_t   pads,
    input  wire logic [19:0] ext_drv,
    input  wire logic [19:0] ext_oe,
    output logic      [19:0] level
);
    logic [19:0] wobble_q = 20'h5_5555;

    // a floating line toggles, so a missing pull-up never reads stable
    always @(posedge clk_sys) begin
        wobble_q <= ~wobble_q;
    end

    // device drive wins, then the far side, then the weak pull-up
    always_comb begin
        for (int n = 0; n < 20; n++) begin
            if (pads.oe[n])
                level[n] = pads.drive[n];
            else if (ext_oe[n])
                level[n] = ext_drv[n];
            else if (pads.pull_en[n])
                level[n] = 1'b1;
            else
                level[n] = wobble_q[n];
        end
    end
endmodule : line_pad_model

//--- test/test_digital_line_port.sv
// self-checking bench of digital_line_port with a pad model
// assumes a shortened power-up hold and no stored state across rst_n
`timescale 1ns/1ps
`include "line_port_defines.svh"

module test_digital_line_port
    import line_port_pkg::*;
;
    localparam int HOLD = 20;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [19:0] pin_lvl;
    logic [19:0] ext_drv = 20'h0_0000;
    logic [19:0] ext_oe = 20'h0_0000;
    logic [31:0] rd_val;
    pad_ctrl_t   pads;
    logic        startup_done;
    logic [31:0] reg_rdata_hv;
    logic [31:0] rd_hv;
    pad_ctrl_t   pads_hv;
    logic        done_hv;
    int          cyc = 0;
    int          miscompares = 0;
    int          check_count = 0;

    always #2 clk_sys = ~clk_sys;

    // edges since reset release, for the hold length
    always @(posedge clk_sys) if (rst_n) cyc++;

    digital_line_port #(
        .HV_VARIANT     (1'b0),
        .STARTUP_CYCLES (HOLD)
    ) digital_line_port_i (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .pin_in       (pin_lvl),
        .pads         (pads),
        .startup_done (startup_done)
    );

    // variant on the same bus: its low four lines must stay dead
    digital_line_port #(
        .HV_VARIANT     (1'b1),
        .STARTUP_CYCLES (HOLD)
    ) digital_line_port_hv_i (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata_hv),
        .pin_in       (pin_lvl),
        .pads         (pads_hv),
        .startup_done (done_hv)
    );

    line_pad_model line_pad_model_i (
        .clk_sys (clk_sys),
        .pads    (pads),
        .ext_drv (ext_drv),
        .ext_oe  (ext_oe),
        .level   (pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    function automatic logic [31:0] z(input logic [19:0] v);
        return {12'h000, v};
    endfunction : z

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // strobe held one cycle, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
        rd_hv  = reg_rdata_hv;
    endtask : rd

    // pads follow the registers one cycle after they change
    task automatic pads_are(input logic [19:0] oe, input logic [19:0] dv);
        repeat (2) @(posedge clk_sys);
        #1;
        check(z(pads.oe), z(oe));
        check(z(pads.drive & oe), z(dv & oe));
        check(z(pads.pull_en), z(~oe));
    endtask : pads_are

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_powerup();
        #1;
        check(z(pads.pull_en), 32'h000F_FFFF);
        check(z(pads_hv.pull_en), 32'h000F_FFF0);
        check(z(pads.oe), 32'h0000_0000);
        wr(`DLP_OFF_PU_DIR, 32'h0000_0005);
        wr(`DLP_OFF_PU_LEVEL, 32'h0000_0001);
        wr(`DLP_OFF_DIR, 32'h000F_FFFF);
        pads_are(20'h0_0000, 20'h0_0000);
        check({31'h0000_0000, startup_done}, 32'h0000_0000);
        for (int i = 0; i < 40 && startup_done !== 1'b1; i++) begin
            @(posedge clk_sys);
            #1;
        end
        check({31'h0000_0000, startup_done}, 32'h0000_0001);
        check({31'h0000_0000, (cyc >= HOLD)}, 32'h0000_0001);
        pads_are(20'h0_0005, 20'h0_0001);
        rd(`DLP_OFF_DIR);
        check(rd_val, 32'h0000_0005);
        $display("t_powerup done");
    endtask : t_powerup

    task automatic t_lines();
        logic [19:0] dir_t [3] = '{20'hF_FFFF, 20'h0_FF00, 20'hF_00F0};
        logic [19:0] lvl_t [3] = '{20'hA_5A5A, 20'h5_0F0F, 20'h3_FFC3};
        logic [19:0] e;
        for (int k = 0; k < 3; k++) begin
            wr(`DLP_OFF_DIR, z(dir_t[k]));
            wr(`DLP_OFF_LEVEL, z(lvl_t[k]));
            pads_are(dir_t[k], lvl_t[k]);
            repeat (3) @(posedge clk_sys);
            rd(`DLP_OFF_PINS);
            e = (dir_t[k] & lvl_t[k]) | ~dir_t[k];
            check(rd_val, z(e));
        end
        $display("t_lines done");
    endtask : t_lines

    // far side drives the low twelve inputs over the pull-up, then one exchange
    task automatic t_xchg();
        wr(`DLP_OFF_DIR, 32'h000F_F000);
        ext_oe  <= 20'h0_0FFF;
        ext_drv <= 20'h0_0A5C;
        repeat (4) @(posedge clk_sys);
        wr(`DLP_OFF_XCHG, 32'h0005_A000);
        pads_are(20'hF_F000, 20'h5_A000);
        rd(`DLP_OFF_XCHG);
        check(rd_val, 32'h0003_FA5C);
        repeat (3) @(posedge clk_sys);
        rd(`DLP_OFF_PINS);
        check(rd_val, 32'h0005_AA5C);
        ext_oe <= 20'h0_0000;
        $display("t_xchg done");
    endtask : t_xchg

    task automatic t_bus();
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C);
        check(rd_val, 32'h0000_0000);
        rd(`DLP_OFF_LEVEL);
        check(rd_val, 32'h0005_A000);
        @(posedge clk_sys);
        #1;
        check(reg_rdata, 32'h0000_0000);
        wr(`DLP_OFF_LEVEL, 32'hFFFF_FFFF);
        rd(`DLP_OFF_LEVEL);
        check(rd_val, 32'h000F_FFFF);
        rd(`DLP_OFF_STATUS);
        check(rd_val, 32'h0000_0001);
        $display("t_bus done");
    endtask : t_bus

    // variant saw every write above; absent lines dropped them all
    task automatic t_hv();
        check({31'h0000_0000, done_hv}, 32'h0000_0001);
        check(z(pads_hv.oe), 32'h000F_F000);
        check(z(pads_hv.drive), 32'h000F_F000);
        check(z(pads_hv.pull_en), 32'h0000_0FF0);
        rd(`DLP_OFF_STATUS);
        check(rd_hv, 32'h0000_0003);
        rd(`DLP_OFF_PINS);
        check(rd_hv, 32'h000F_FFF0);
        wr(`DLP_OFF_DIR, 32'h0000_000F);
        rd(`DLP_OFF_DIR);
        check(rd_val, 32'h0000_000F);
        check(rd_hv, 32'h0000_0000);
        check(z(pads_hv.oe), 32'h0000_0000);
        $display("t_hv done");
    endtask : t_hv

    ////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_powerup();
        t_lines();
        t_xchg();
        t_bus();
        t_hv();
        give_verdict();
    end

    // the run needs about a hundred cycles; 2000 means a hang
    initial begin
        #8000;
        miscompares++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : test_digital_line_port
